// file: core/sarctl_pkg.sv
// sarctl_pkg: constants, states and state types shared by the converter sequencer
package sarctl_pkg;

  // control byte field positions
  localparam int unsigned CTRL_ON_BIT    = 0;          // module-on
  localparam int unsigned CTRL_GO_BIT    = 1;          // go / busy
  localparam int unsigned CTRL_CHAN_LSB  = 2;          // channel select low bit
  localparam int unsigned CTRL_REF_BIT   = 6;          // reference select
  localparam int unsigned CTRL_JUST_BIT  = 7;          // justify select
  localparam logic [7:0]  CTRL_RESET     = 8'h00;      // control byte after reset

  // conversion figures
  localparam int unsigned CONV_BITS      = 10;         // result width
  localparam int unsigned CONV_PERIODS   = 11;         // bit periods per conversion
  localparam logic [3:0]  LAST_PERIOD    = 4'(CONV_PERIODS - 1);
  localparam int unsigned ABORT_HOLD     = 2;          // bit periods after an abort
  localparam logic [1:0]  LAST_HOLD      = 2'(ABORT_HOLD - 1);
  localparam logic [9:0]  SAR_FIRST      = 10'h200;    // first trial code, msb set
  localparam logic [7:0]  RESULT_RESET   = 8'h00;      // result bytes after reset

  // one instruction cycle of delay before an rc-clocked conversion
  localparam int unsigned CLK_NS         = 10;         // mclk period
  localparam int unsigned INSTR_NS       = 40;         // one instruction cycle
  localparam int unsigned INSTR_CYCLES   = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0]  LAST_INSTR     = 3'(INSTR_CYCLES - 1);

  // clock select: low two bits both set picks the rc clock
  localparam logic [1:0]  CLKSEL_RC      = 2'h3;
  localparam logic [6:0]  DIV_BASE       = 7'h02;      // fosc/2 is the shortest period

  typedef enum logic [1:0] {
    SARCTL_IDLE,     // acquiring or off
    SARCTL_RCDELAY,  // one instruction delay for rc clock
    SARCTL_CONVERT,  // successive approximation
    SARCTL_HOLDOFF   // dead time after abort
  } sarctl_state_t;

  typedef struct packed {
    logic [6:0] cnt;      // fosc divider count
    logic       frcMeta;  // rc clock sync stage 1
    logic       frcSync;  // rc clock sync stage 2
    logic       frcPrev;  // previous synced rc level
    logic       tick;     // one bit period elapsed
  } sarctl_div_t;

  typedef struct packed {
    sarctl_state_t state;
    logic          on;
    logic          go;
    logic          justify;
    logic          refExt;
    logic [1:0]    chan;
    logic          doneFlag;
    logic          powerDown;
    logic          sleepPrev;
    logic [9:0]    sar;
    logic [3:0]    bitCnt;
    logic [1:0]    holdCnt;
    logic [2:0]    delayCnt;
    logic [7:0]    resHigh;
    logic [7:0]    resLow;
    logic          timerReset;
  } sarctl_core_t;

endpackage

// file: core/sarctl_bit_clock.sv
// sarctl_bit_clock: bit period tick from divided mclk or the rc oscillator
`timescale 1ns/1ns
`default_nettype none
module sarctl_bit_clock
  import sarctl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       run,         // count only while sequencer needs ticks
  input  wire logic [2:0] clockSelect, // conversion clock select field
  input  wire logic       frcPin,      // rc oscillator, asynchronous to mclk
  output logic            bitTick      // one-cycle pulse per bit period
);

  sarctl_div_t q;  // registered state
  sarctl_div_t d;  // next state
  logic [6:0]  period;
  logic [2:0]  shift;

  // divider: next tick and sync chain
  always_comb begin
    d = q;
    // shift order 000,100,001,101,010,110 gives /2../64
    shift     = {clockSelect[1:0], clockSelect[2]};
    period    = DIV_BASE << shift;
    d.frcMeta = frcPin;
    d.frcSync = q.frcMeta;  // first stage feeds nothing else
    d.frcPrev = q.frcSync;
    d.tick    = 1'b0;
    if (!run) begin
      // restart so each fosc-clocked conversion sees full periods; rc edges keep their own phase
      d.cnt = 7'h00;
    end else if (clockSelect[1:0] == CLKSEL_RC) begin
      // rc clock: one period per rising edge
      d.tick = q.frcSync & ~q.frcPrev;
    end else if (q.cnt == period - 7'h01) begin
      d.cnt  = 7'h00;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 7'h01;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bitTick = q.tick;

endmodule
`default_nettype wire

// file: core/sarctl_core.sv
// sarctl_core: sequencer for a 10-bit successive-approximation converter
// Contract
// - bit period from fosc divider or rc clock
// - conversion takes exactly eleven bit periods
// - channel field drives sample-and-hold mux
// - positive reference supply or external; negative ground
// - control bit 6 selects external reference
// - result spread over high/low, justified
// - control bit 7 one means right justify
// - done flag set every conversion end
// - interrupt on flag and enable; wakes sleep
// - go write starts when module on
// - completion clears go, sets flag, loads result
// - go cleared mid-conversion aborts, keeps result
// - abort holds two bit periods, then acquires
// - reset clears control, stops conversion
// - rc clock adds one instruction delay
// - rc sleep without interrupt powers down after
// - sleep with other clock aborts, powers down
// - trigger sets go, resets timer counter
`timescale 1ns/1ns
`default_nettype none
module sarctl_core
  import sarctl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  // software access to the control byte, other software controls and analog-side inputs
  input  wire logic       ctrlWrite,       // one-cycle write strobe
  input  wire logic [7:0] ctrlWrData,      // written control byte
  output logic [7:0]      ctrlRdData,      // control byte readback
  input  wire logic [2:0] convClockSelect, // conversion clock select field
  input  wire logic       doneFlagClear,   // one-cycle clear of done flag
  input  wire logic       doneIrqEnable,   // done interrupt enable
  input  wire logic       sleepMode,       // core is in sleep
  input  wire logic       specialTrigger,  // compare unit event, one cycle
  input  wire logic       frcPin,          // rc oscillator, asynchronous
  input  wire logic       compareHigh,     // analog comparator, settles from trialCode within a cycle
  // analog side controls
  output logic [1:0]      channelSelect,   // mux select to sample-and-hold
  output logic            referenceExt,    // positive reference from pin
  output logic            sampleHold,      // high while acquiring
  output logic [9:0]      trialCode,       // dac code under test
  output logic            convPowered,     // analog section powered
  // results and events
  output logic [7:0]      resultHigh,      // high result byte
  output logic [7:0]      resultLow,       // low result byte
  output logic            convDoneFlag,    // sticky done flag
  output logic            convIrq,         // interrupt request level
  output logic            wakeRequest,     // wake from sleep level
  output logic            timerReset       // one-cycle counter reset
);

  sarctl_core_t q;        // registered state
  sarctl_core_t d;        // next state
  logic         bitTick;  // bit period elapsed
  logic         tickRun;  // divider running
  logic         rcSel;    // rc clock chosen
  logic         goWrite;  // software writes go as one
  logic         goClear;  // software writes go as zero
  logic         offWrite; // software turns module off
  logic         busy;     // conversion or its delay underway
  logic         sleepIn;  // sleep just entered
  logic         startReq; // start request this cycle
  logic [3:0]   idx;      // sar bit being resolved

  // divider only runs when a state consumes ticks
  // a state change stops it for one cycle, so holdoff counts whole fosc bit periods
  assign tickRun = ((q.state == SARCTL_CONVERT) || (q.state == SARCTL_HOLDOFF)) && (d.state == q.state);

  sarctl_bit_clock u_bit_clock (
    .mclk        (mclk),
    .srst        (srst),
    .run         (tickRun),
    .clockSelect (convClockSelect),
    .frcPin      (frcPin),
    .bitTick     (bitTick)
  );

  // request decode from software and trigger
  always_comb begin
    rcSel    = (convClockSelect[1:0] == CLKSEL_RC);
    goWrite  = ctrlWrite & ctrlWrData[CTRL_GO_BIT];
    goClear  = ctrlWrite & ~ctrlWrData[CTRL_GO_BIT];
    offWrite = ctrlWrite & ~ctrlWrData[CTRL_ON_BIT];
    busy     = (q.state == SARCTL_RCDELAY) || (q.state == SARCTL_CONVERT);
    sleepIn  = sleepMode & ~q.sleepPrev;
    // module must already be on; a write turning it on cannot start
    startReq = (goWrite | specialTrigger) & q.on & (q.state == SARCTL_IDLE);
  end

  // next-state logic of the sequencer
  always_comb begin
    d            = q;
    idx          = 4'(CONV_BITS) - q.bitCnt;
    d.sleepPrev  = sleepMode;
    d.timerReset = specialTrigger;
    // leaving sleep restores analog power
    if (!sleepMode) begin
      d.powerDown = 1'b0;
    end
    // plain configuration bits follow every write
    if (ctrlWrite) begin
      d.on      = ctrlWrData[CTRL_ON_BIT];
      d.chan    = ctrlWrData[CTRL_CHAN_LSB +: 2];
      d.refExt  = ctrlWrData[CTRL_REF_BIT];
      d.justify = ctrlWrData[CTRL_JUST_BIT];
    end
    // clear first so a same-cycle completion wins
    if (doneFlagClear) begin
      d.doneFlag = 1'b0;
    end
    unique case (q.state)
      SARCTL_IDLE: begin
        if (startReq) begin
          d.go       = 1'b1;
          d.bitCnt   = 4'h0;
          d.delayCnt = 3'h0;
          d.state    = rcSel ? SARCTL_RCDELAY : SARCTL_CONVERT;
        end
      end
      SARCTL_RCDELAY: begin
        // lets a sleep instruction execute before conversion starts
        if (q.delayCnt == LAST_INSTR) begin
          d.state = SARCTL_CONVERT;
        end else begin
          d.delayCnt = q.delayCnt + 3'h1;
        end
      end
      SARCTL_CONVERT: begin
        if (bitTick) begin
          if (q.bitCnt == 4'h0) begin
            // first period: sample closes, msb trial loaded
            d.sar    = SAR_FIRST;
            d.bitCnt = 4'h1;
          end else begin
            // keep the trial bit only if input is at or above it
            // comparator answers the registered code, so no sync stage; fosc/2 needs that
            if (!compareHigh) begin
              d.sar[idx] = 1'b0;
            end
            if (idx != 4'h0) begin
              d.sar[idx - 4'h1] = 1'b1;
            end
            if (q.bitCnt == LAST_PERIOD) begin
              // eleventh period ends the conversion
              d.go       = 1'b0;
              d.doneFlag = 1'b1;
              d.state    = SARCTL_IDLE;
              if (q.justify) begin
                // right: two bits high, eight low
                d.resHigh = {6'h00, d.sar[9:8]};
                d.resLow  = d.sar[7:0];
              end else begin
                // left: eight bits high, two low
                d.resHigh = d.sar[9:2];
                d.resLow  = {d.sar[1:0], 6'h00};
              end
              // rc conversion in sleep with no wake source
              if (sleepMode && rcSel && !doneIrqEnable) begin
                d.powerDown = 1'b1;
              end
            end else begin
              d.bitCnt = q.bitCnt + 4'h1;
            end
          end
        end
      end
      SARCTL_HOLDOFF: begin
        // no acquisition until two bit periods pass
        if (bitTick) begin
          if (q.holdCnt == LAST_HOLD) begin
            d.state = SARCTL_IDLE;
          end else begin
            d.holdCnt = q.holdCnt + 2'h1;
          end
        end
      end
    endcase
    // aborts override any progress made above
    if (busy) begin
      if (ctrlWrite && offWrite) begin
        // module switched off: stop without dead time
        d.go    = 1'b0;
        d.state = SARCTL_IDLE;
        d.sar   = q.sar;
      end else if (goClear) begin
        // partial result dropped, result bytes untouched
        d.go       = 1'b0;
        d.holdCnt  = 2'h0;
        d.state    = SARCTL_HOLDOFF;
        d.sar      = q.sar;
        d.doneFlag = doneFlagClear ? 1'b0 : q.doneFlag;
        d.resHigh  = q.resHigh;
        d.resLow   = q.resLow;
      end else if (sleepIn && !rcSel) begin
        // fosc stops in sleep, so the conversion cannot finish
        d.go        = 1'b0;
        d.state     = SARCTL_IDLE;
        d.powerDown = 1'b1;
        d.sar       = q.sar;
        d.doneFlag  = doneFlagClear ? 1'b0 : q.doneFlag;
        d.resHigh   = q.resHigh;
        d.resLow    = q.resLow;
      end
    end
  end

  // single state register; reset clears every control bit
  always_ff @(posedge mclk) begin
    if (srst) begin
      q          <= '0;
      q.state    <= SARCTL_IDLE;
      q.on       <= CTRL_RESET[CTRL_ON_BIT];
      q.go       <= CTRL_RESET[CTRL_GO_BIT];
      q.justify  <= CTRL_RESET[CTRL_JUST_BIT];
      q.refExt   <= CTRL_RESET[CTRL_REF_BIT];
      q.chan     <= CTRL_RESET[CTRL_CHAN_LSB +: 2];
      q.resHigh  <= RESULT_RESET;
      q.resLow   <= RESULT_RESET;
    end else begin
      q <= d;
    end
  end

  // readback: unused bits 5:4 read as zero; go stays one while busy
  assign ctrlRdData    = {q.justify, q.refExt, 2'b00, q.chan, q.go, q.on};
  assign channelSelect = q.chan;
  assign referenceExt  = q.refExt;
  // acquisition runs whenever powered and idle, not converting or in holdoff
  assign sampleHold    = q.on & ~q.powerDown & (q.state == SARCTL_IDLE);
  assign trialCode     = q.sar;
  // on bit still reads set while powered down
  assign convPowered   = q.on & ~q.powerDown;
  assign resultHigh    = q.resHigh;
  assign resultLow     = q.resLow;
  assign convDoneFlag  = q.doneFlag;
  assign convIrq       = q.doneFlag & doneIrqEnable;
  assign wakeRequest   = q.doneFlag & doneIrqEnable & sleepMode;
  assign timerReset    = q.timerReset;

endmodule
`default_nettype wire

// file: testbench/sarctl_core_props.sv
// sarctl_core_props: port-level assertions for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sarctl_core_props
  import sarctl_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic [7:0] ctrlRdData,
  input wire logic       doneFlagClear,
  input wire logic       doneIrqEnable,
  input wire logic       sleepMode,
  input wire logic       specialTrigger,
  input wire logic [1:0] channelSelect,
  input wire logic       referenceExt,
  input wire logic       sampleHold,
  input wire logic [7:0] resultHigh,
  input wire logic [7:0] resultLow,
  input wire logic       convDoneFlag,
  input wire logic       convIrq,
  input wire logic       timerReset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic busy = ctrlRdData[CTRL_GO_BIT];  // go bit doubles as busy
  property p_irq; convIrq == (convDoneFlag && doneIrqEnable); endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_timer; timerReset == $past(specialTrigger); endproperty
  a_timer: assert property (p_timer) else $error("timer reset pulse wrong");
  // only software may drop the flag
  property p_sticky; convDoneFlag && !doneFlagClear |=> convDoneFlag; endproperty
  a_sticky: assert property (p_sticky) else $error("done flag lost");
  // results move only on a completion, never on an abort
  property p_result; !$stable({resultHigh, resultLow}) && !$past(srst) |-> convDoneFlag && $fell(busy); endproperty
  a_result: assert property (p_result) else $error("result changed off completion");
  property p_ref; referenceExt == ctrlRdData[CTRL_REF_BIT]; endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_chan; channelSelect == ctrlRdData[CTRL_CHAN_LSB +: 2]; endproperty
  a_chan: assert property (p_chan) else $error("channel select wrong");
  property p_busy; $rose(busy) |=> busy [*8]; endproperty
  a_busy: assert property (p_busy) else $error("go dropped early");
  property p_reset; $fell(srst) |-> ctrlRdData == CTRL_RESET && resultHigh == RESULT_RESET && !convDoneFlag; endproperty
  a_reset: assert property (p_reset) else $error("state after reset wrong");
  // abort: dead time before acquisition resumes, bounded wait
  property p_abort; $fell(busy) && !convDoneFlag && ctrlRdData[CTRL_ON_BIT] && !sleepMode
    |-> !sampleHold [*3] ##[1:300] sampleHold; endproperty
  a_abort: assert property (p_abort) else $error("abort holdoff wrong");
  property p_right; $rose(convDoneFlag) && ctrlRdData[CTRL_JUST_BIT] |-> resultHigh[7:2] == 6'h00; endproperty
  a_right: assert property (p_right) else $error("right justify wrong");
  c_done: cover property ($fell(busy) && convDoneFlag);
  c_abort: cover property ($fell(busy) && !convDoneFlag);
  c_trig: cover property (timerReset);
endmodule
bind sarctl_core sarctl_core_props i_sarctl_core_props (.mclk, .srst, .ctrlRdData, .doneFlagClear,
  .doneIrqEnable, .sleepMode, .specialTrigger, .channelSelect, .referenceExt, .sampleHold,
  .resultHigh, .resultLow, .convDoneFlag, .convIrq, .timerReset);
`default_nettype wire

// file: testbench/sarctl_analog_model.sv
// sarctl_analog_model: comparator and rc oscillator on the analog side
`timescale 1ns/1ns
`default_nettype none
module sarctl_analog_model (
  input  wire logic [1:0]      channelSelect,
  input  wire logic [9:0]      trialCode,
  input  wire logic            convPowered,
  input  wire logic [3:0][9:0] levels,
  output var logic             compareHigh,
  output var logic             frcPin
);
  logic noise = 1'b0;  // unpowered comparator output wanders
  initial frcPin = 1'b0;
  always #7 noise = ~noise;
  // rc oscillator runs free at 230 ns, unrelated to mclk
  always #115 frcPin = ~frcPin;
  // keep the trial bit while the selected input is at or above the code
  always_comb compareHigh = convPowered ? (levels[channelSelect] >= trialCode) : noise;
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// tb_top: self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import sarctl_pkg::*;
;
  logic            mclk = 1'b0, srst = 1'b1, ctrlWrite = 1'b0, doneFlagClear = 1'b0;
  logic            doneIrqEnable = 1'b0, sleepMode = 1'b0, specialTrigger = 1'b0;
  logic [7:0]      ctrlWrData = 8'h00;
  logic [2:0]      convClockSelect = 3'h0;
  logic [7:0]      ctrlRdData, resultHigh, resultLow;
  logic [1:0]      channelSelect;
  logic [9:0]      trialCode;
  logic            frcPin, compareHigh, referenceExt, sampleHold, convPowered;
  logic            convDoneFlag, convIrq, wakeRequest, timerReset;
  logic [3:0][9:0] levels = {10'h3ff, 10'h000, 10'h2a5, 10'h15a};  // analog input per channel
  int              error_cnt = 0, n_tests = 0, lat;
  always #5 mclk = ~mclk;
  sarctl_core i_sarctl_core (.mclk, .srst, .ctrlWrite, .ctrlWrData, .ctrlRdData, .convClockSelect,
    .doneFlagClear, .doneIrqEnable, .sleepMode, .specialTrigger, .frcPin, .compareHigh, .channelSelect,
    .referenceExt, .sampleHold, .trialCode, .convPowered, .resultHigh, .resultLow, .convDoneFlag,
    .convIrq, .wakeRequest, .timerReset);
  sarctl_analog_model i_sarctl_analog_model (.channelSelect, .trialCode, .convPowered, .levels,
    .compareHigh, .frcPin);
  // inputs always move 1 ns after the rising edge
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    ctrlWrite = 1'b1;
    ctrlWrData = d;
    cyc();
    ctrlWrite = 1'b0;
  endtask
  task automatic clr();
    doneFlagClear = 1'b1;
    cyc();
    doneFlagClear = 1'b0;
  endtask
  // bounded poll of the go bit, lat counts edges since the start
  task automatic wait_idle();
    lat = 0;
    while (ctrlRdData[CTRL_GO_BIT] === 1'b1 && lat < 2000) begin
      cyc();
      lat++;
    end
  endtask
  function automatic logic [15:0] fmt(input logic [9:0] r, input logic right);
    return right ? {6'h00, r} : {r, 6'h00};
  endfunction
  task automatic check_reset();
    chk({ctrlRdData, resultHigh}, 16'h0000, "control after reset");
    chk({resultLow, 6'h00, convDoneFlag, convPowered}, 16'h0000, "results after reset");
    $display("reset check done");
  endtask
  // every fosc divider: length within three cycles, result and flag
  task automatic t_clocks();
    logic [2:0] sel [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    for (int i = 0; i < 6; i++) begin
      convClockSelect = sel[i];
      wr({4'h8, 2'(i), 2'h1});
      cyc(8);  // acquisition after channel change
      wr({4'h8, 2'(i), 2'h3});
      wait_idle();
      chk(16'(lat >= 22 << i && lat <= (22 << i) + 3), 16'h0001, "conversion length");
      chk({resultHigh, resultLow}, fmt(levels[2'(i)], 1'b1), "right result");
      chk(16'(convDoneFlag), 16'h0001, "done flag");
      clr();
    end
    $display("clock select test done");
  endtask
  task automatic t_left();
    doneIrqEnable = 1'b1;
    wr(8'h45);
    cyc(8);
    chk(16'(referenceExt), 16'h0001, "external reference");
    wr(8'h47);
    wait_idle();
    chk({resultHigh, resultLow}, fmt(levels[1], 1'b0), "left result");
    chk(16'(convIrq), 16'h0001, "irq raised");
    sleepMode = 1'b1;
    cyc();
    chk({convIrq, wakeRequest}, 16'h0003, "wake in sleep");
    sleepMode = 1'b0;
    clr();
    chk(16'(convIrq), 16'h0000, "irq cleared");
    doneIrqEnable = 1'b0;
    $display("left justify test done");
  endtask
  task automatic t_same();
    wr(8'h00);
    cyc();
    wr(8'h83);
    chk(16'(ctrlRdData[CTRL_GO_BIT]), 16'h0000, "go with turn-on");
    cyc(8);
    wr(8'h83);
    chk(16'(ctrlRdData[CTRL_GO_BIT]), 16'h0001, "go started");
    wait_idle();
    chk({resultHigh, resultLow}, fmt(levels[0], 1'b1), "result after turn-on");
    clr();
    $display("turn-on test done");
  endtask
  task automatic t_abort();
    logic [15:0] saved;
    wr(8'h8d);
    cyc(8);
    saved = {resultHigh, resultLow};
    wr(8'h8f);
    cyc(10);
    wr(8'h8d);
    chk({ctrlRdData[CTRL_GO_BIT], convDoneFlag}, 16'h0000, "abort state");
    chk({resultHigh, resultLow}, saved, "result kept");
    lat = 0;
    while (sampleHold !== 1'b1 && lat < 300) begin
      cyc();
      lat++;
    end
    // two full fosc/64 bit periods
    chk(16'(lat >= 128 && lat <= 130), 16'h0001, "holdoff length");
    $display("abort test done");
  endtask
  task automatic t_trig();
    wr(8'h81);
    cyc(8);  // software keeps acquisition time
    specialTrigger = 1'b1;
    cyc();
    specialTrigger = 1'b0;
    chk({timerReset, ctrlRdData[CTRL_GO_BIT]}, 16'h0003, "trigger start");
    wait_idle();
    chk(16'(convDoneFlag), 16'h0001, "trigger done");
    clr();
    $display("trigger test done");
  endtask
  // rc clock survives sleep, then powers down without irq
  task automatic t_rc();
    convClockSelect = 3'h3;
    wr(8'h83);
    sleepMode = 1'b1;
    cyc(6);
    chk(16'(ctrlRdData[CTRL_GO_BIT]), 16'h0001, "rc conversion in sleep");
    wait_idle();
    chk({convDoneFlag, convPowered, ctrlRdData[CTRL_ON_BIT]}, 16'h0005, "rc sleep end");
    sleepMode = 1'b0;
    clr();
    $display("rc sleep test done");
  endtask
  task automatic t_sleep();
    convClockSelect = 3'h1;
    wr(8'h83);
    cyc(10);
    sleepMode = 1'b1;
    cyc(2);
    chk({ctrlRdData[1:0], convPowered, convDoneFlag}, 16'h0004, "sleep abort");
    sleepMode = 1'b0;
    cyc(2);
    wr(8'h83);
    cyc(5);
    srst = 1'b1;
    cyc();
    srst = 1'b0;
    check_reset();
    $display("sleep and reset test done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(4);
    srst = 1'b0;
    check_reset();
    t_clocks();
    t_left();
    t_same();
    t_abort();
    t_trig();
    t_rc();
    t_sleep();
    close_out();
  end
  // run needs about 4000 cycles; cut a hang at 20000
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
